// ---- src/laser_drive_regs.svh ----
// register offsets, field positions and reset values of the laser drive register set
`ifndef LASER_DRIVE_REGS_SVH
`define LASER_DRIVE_REGS_SVH

// register indexes; byte address is four times the index
`define LDC_IDX_CTRL 7'h1A
`define LDC_IDX_CODE 7'h1C
`define LDC_IDX_CODE_INV 7'h1D
`define LDC_IDX_SPAN_INV 7'h1F
`define LDC_IDX_MOTION_A 7'h02
`define LDC_IDX_MOTION_B 7'h42
`define LDC_IDX_IRQ_STATUS 7'h50
`define LDC_IDX_IRQ_MASK 7'h51

// reset values
`define LDC_RST_BYTE 8'h00
`define LDC_RST_SPAN 2'h0
`define LDC_RST_EVENTS 3'h0

// laser drive control layout
`define LDC_CTRL_WMASK 8'hCF
`define LDC_CAL_CW 3'h5
`define LDC_CAL_OFF 3'h0
`define LDC_SPAN_BAD 2'h2

// range inverse register layout
`define LDC_SPAN_INV_MSB 7
`define LDC_SPAN_INV_LSB 6

// motion status layout
`define LDC_MOTION_VALID_BIT 0

// dac scale in 1/384 of full current
`define LDC_DAC_OFFSET 9'h081
`define LDC_DAC_FULL 9'h180

`endif

// ---- src/laser_drive_pkg.sv ----
// types shared by the laser drive register set
package laser_drive_pkg;

    typedef struct packed {
        logic [1:0] span;
        logic [1:0] rsvd;
        logic [2:0] cal;
        logic force_off;
    } drive_ctrl_t;

    typedef struct packed {
        logic sel;
        logic enable;
        logic write;
        logic [11:0] addr;
        logic [31:0] wdata;
    } apb_req_t;

    typedef struct packed {
        logic cal_ended;
        logic valid_gained;
        logic valid_lost;
    } event_bits_t;

endpackage

// ---- src/inverse_pair_check.sv ----
// registered check that two values are exact bitwise inverses
`timescale 1ns/1ps

module inverse_pair_check #(
    parameter int W = 8
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    input wire logic [W-1:0] i_value,
    input wire logic [W-1:0] i_inverse,
    output logic o_match
);

    logic match_r;

    // =========================================
    // comparison of held values only
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            match_r <= 1'b0;
        end else if (i_ce) begin
            match_r <= (i_value == ~i_inverse);
        end
    end

    assign o_match = match_r;

endmodule

// ---- src/laser_drive_control_regs.sv ----
// laser drive control register set with apb slave, validity checks and interrupt
// Function
// - laser off and valid flag cleared unless span bits inverse the range inverse bits
// - pairs written in any order; validity judged only from held values
// - span code 00, 01, 11 select the low, middle and high current span
// - span code 10 is invalid: laser off, valid flag cleared
// - calibration field 101 keeps the laser continuously on
// - reading motion status at either address clears calibration field to 000
// - force-disable bit set drives the active-low laser enable high
// - current code drives dac, 33.59 to 100 percent in 1/384 steps
// - laser off and valid flag cleared unless code inverse is exact complement
// - control, code and code inverse registers read/write, reset to zero, laser off
// - range inverse register holds inverse span bits in bits 7 and 6
`timescale 1ns/1ps

`include "laser_drive_regs.svh"

module laser_drive_control_regs
    import laser_drive_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic I_CLK,
    input wire logic I_RSTN,
    input wire logic I_CE,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [ADDR_W-1:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    input wire logic I_EXPOSE,
    output logic O_LASER_DRIVE_ENABLE_LOW,
    output logic [1:0] O_CURRENT_SPAN_SELECT,
    output logic [7:0] O_DAC_CODE,
    output logic [8:0] O_DAC_SCALE,
    output logic O_CONTINUOUS_WAVE,
    output logic O_LASER_POWER_VALID,
    output logic O_IRQ
);

    // =========================================
    // bus request and decode
    apb_req_t req;
    logic setup_w;
    logic acc_w;
    logic wr_w;
    logic rd_w;
    logic idx_ok_w;
    logic [6:0] idx_w;
    logic hit_w;
    logic [7:0] rdata_nxt;
    logic sel_ctrl;
    logic sel_code;
    logic sel_code_inv;
    logic sel_span_inv;
    logic sel_motion;
    logic sel_irq_st;
    logic sel_irq_mask;

    // =========================================
    // register state
    drive_ctrl_t ctrl_r;
    logic [7:0] code_r;
    logic [7:0] code_inv_r;
    logic [1:0] span_inv_r;
    event_bits_t irq_st_r;
    event_bits_t irq_mask_r;
    event_bits_t events_w;
    logic [31:0] prdata_r;
    logic slverr_r;

    // =========================================
    // laser control state
    logic span_match;
    logic code_match;
    logic span_ok_w;
    logic cw_w;
    logic valid_w;
    logic drive_on_w;
    logic valid_r;
    logic drive_low_r;
    logic [1:0] span_out_r;
    logic [7:0] dac_code_r;
    logic [8:0] dac_scale_r;
    logic cw_r;
    logic irq_r;

    assign req.sel = I_PSEL;
    assign req.enable = I_PENABLE;
    assign req.write = I_PWRITE;
    assign req.addr = 12'(I_PADDR);
    assign req.wdata = I_PWDATA;

    // zero-wait slave; a frozen clock enable holds the access
    assign O_PREADY = I_CE;
    assign setup_w = req.sel & ~req.enable & I_CE;
    assign acc_w = req.sel & req.enable & I_CE;
    assign wr_w = acc_w & req.write;
    assign rd_w = acc_w & ~req.write;
    assign idx_w = req.addr[8:2];
    assign idx_ok_w = (req.addr[11:9] == 3'h0) && (req.addr[1:0] == 2'h0);

    // =========================================
    // address decode and read mux
    always_comb begin
        sel_ctrl = 1'b0;
        sel_code = 1'b0;
        sel_code_inv = 1'b0;
        sel_span_inv = 1'b0;
        sel_motion = 1'b0;
        sel_irq_st = 1'b0;
        sel_irq_mask = 1'b0;
        rdata_nxt = 8'h00;
        if (!idx_ok_w) begin
            rdata_nxt = 8'h00;
        end else if (idx_w == `LDC_IDX_CTRL) begin
            sel_ctrl = 1'b1;
            rdata_nxt = ctrl_r;
        end else if (idx_w == `LDC_IDX_CODE) begin
            sel_code = 1'b1;
            rdata_nxt = code_r;
        end else if (idx_w == `LDC_IDX_CODE_INV) begin
            sel_code_inv = 1'b1;
            rdata_nxt = code_inv_r;
        end else if (idx_w == `LDC_IDX_SPAN_INV) begin
            sel_span_inv = 1'b1;
            rdata_nxt = {span_inv_r, 6'h00};
        end else if (idx_w == `LDC_IDX_MOTION_A || idx_w == `LDC_IDX_MOTION_B) begin
            sel_motion = 1'b1;
            rdata_nxt[`LDC_MOTION_VALID_BIT] = valid_r;
        end else if (idx_w == `LDC_IDX_IRQ_STATUS) begin
            sel_irq_st = 1'b1;
            rdata_nxt = {5'h00, irq_st_r};
        end else if (idx_w == `LDC_IDX_IRQ_MASK) begin
            sel_irq_mask = 1'b1;
            rdata_nxt = {5'h00, irq_mask_r};
        end
    end

    assign hit_w = sel_ctrl | sel_code | sel_code_inv | sel_span_inv | sel_motion
        | sel_irq_st | sel_irq_mask;

    // =========================================
    // read data and error captured in setup
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            prdata_r <= 32'h00000000;
            slverr_r <= 1'b0;
        end else if (setup_w) begin
            prdata_r <= {24'h000000, rdata_nxt};
            slverr_r <= ~hit_w;
        end
    end

    assign O_PRDATA = prdata_r;
    assign O_PSLVERR = slverr_r & req.sel & req.enable;

    // =========================================
    // laser drive control register
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            ctrl_r <= drive_ctrl_t'(`LDC_RST_BYTE);
        end else if (I_CE) begin
            if (wr_w && sel_ctrl) begin
                ctrl_r <= drive_ctrl_t'(req.wdata[7:0] & `LDC_CTRL_WMASK);
            end else if (rd_w && sel_motion) begin
                ctrl_r.cal <= `LDC_CAL_OFF;
            end
        end
    end

    // =========================================
    // current code, its inverse and the span inverse
    // all pairs reset to zero
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            code_r <= `LDC_RST_BYTE;
            code_inv_r <= `LDC_RST_BYTE;
        end else if (I_CE) begin
            if (wr_w && sel_code) begin
                code_r <= req.wdata[7:0];
            end
            if (wr_w && sel_code_inv) begin
                code_inv_r <= req.wdata[7:0];
            end
        end
    end

    // inverse span bits held in 7:6
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            span_inv_r <= `LDC_RST_SPAN;
        end else if (I_CE && wr_w && sel_span_inv) begin
            span_inv_r <= req.wdata[`LDC_SPAN_INV_MSB:`LDC_SPAN_INV_LSB];
        end
    end

    // =========================================
    // complement checks on held values
    // span against its inverse
    inverse_pair_check #(.W(2)) u_span_check (
        .i_clk(I_CLK),
        .i_rstn(I_RSTN),
        .i_ce(I_CE),
        .i_value(ctrl_r.span),
        .i_inverse(span_inv_r),
        .o_match(span_match)
    );

    inverse_pair_check #(.W(8)) u_code_check (
        .i_clk(I_CLK),
        .i_rstn(I_RSTN),
        .i_ce(I_CE),
        .i_value(code_r),
        .i_inverse(code_inv_r),
        .o_match(code_match)
    );

    assign span_ok_w = (ctrl_r.span != `LDC_SPAN_BAD);
    assign cw_w = (ctrl_r.cal == `LDC_CAL_CW);
    assign valid_w = span_match & code_match & span_ok_w;
    // any failure or force bit removes drive
    assign drive_on_w = valid_w & ~ctrl_r.force_off & (cw_w | I_EXPOSE);

    // =========================================
    // laser outputs
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            valid_r <= 1'b0;
            drive_low_r <= 1'b1;
            cw_r <= 1'b0;
        end else if (I_CE) begin
            valid_r <= valid_w;
            drive_low_r <= ~drive_on_w;
            cw_r <= cw_w & valid_w & ~ctrl_r.force_off;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            span_out_r <= `LDC_RST_SPAN;
            dac_code_r <= `LDC_RST_BYTE;
            dac_scale_r <= `LDC_DAC_OFFSET;
        end else if (I_CE) begin
            span_out_r <= ctrl_r.span;
            dac_code_r <= code_r;
            dac_scale_r <= {1'b0, code_r} + `LDC_DAC_OFFSET;
        end
    end

    assign O_LASER_DRIVE_ENABLE_LOW = drive_low_r;
    assign O_LASER_POWER_VALID = valid_r;
    assign O_CONTINUOUS_WAVE = cw_r;
    assign O_CURRENT_SPAN_SELECT = span_out_r;
    assign O_DAC_CODE = dac_code_r;
    assign O_DAC_SCALE = dac_scale_r;

    // =========================================
    // interrupt status, mask and output
    assign events_w.valid_lost = valid_r & ~valid_w;
    assign events_w.valid_gained = ~valid_r & valid_w;
    assign events_w.cal_ended = rd_w & sel_motion & cw_w;

    // set wins over a write-one clear in the same cycle
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            irq_st_r <= event_bits_t'(`LDC_RST_EVENTS);
        end else if (I_CE) begin
            if (wr_w && sel_irq_st) begin
                irq_st_r <= (irq_st_r & ~event_bits_t'(req.wdata[2:0])) | events_w;
            end else begin
                irq_st_r <= irq_st_r | events_w;
            end
        end
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            irq_mask_r <= event_bits_t'(`LDC_RST_EVENTS);
        end else if (I_CE && wr_w && sel_irq_mask) begin
            irq_mask_r <= event_bits_t'(req.wdata[2:0]);
        end
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            irq_r <= 1'b0;
        end else if (I_CE) begin
            irq_r <= |(irq_st_r & irq_mask_r);
        end
    end

    assign O_IRQ = irq_r;

    // =========================================
    // assertions
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_RSTN);

    logic span_mis_w;
    logic code_mis_w;
    assign span_mis_w = (ctrl_r.span != ~span_inv_r);
    assign code_mis_w = (code_r != ~code_inv_r);

    sequence span_mis_held;
        (span_mis_w && I_CE) [*2];
    endsequence

    sequence code_mis_held;
        (code_mis_w && I_CE) [*2];
    endsequence

    sequence pairs_good_held;
        (!span_mis_w && !code_mis_w && span_ok_w && I_CE) [*2];
    endsequence

    sequence motion_read;
        rd_w && sel_motion;
    endsequence

    span_check_a: assert property (
        span_mis_held |-> (!valid_w ##1 (!valid_r && O_LASER_DRIVE_ENABLE_LOW)))
        else $error("span mismatch did not turn laser off");

    any_order_a: assert property (
        pairs_good_held |=> valid_r)
        else $error("complementary pairs not accepted");

    span_out_a: assert property (
        valid_r |-> (O_CURRENT_SPAN_SELECT != `LDC_SPAN_BAD))
        else $error("invalid span driven while valid");

    bad_span_a: assert property (
        (!span_ok_w && I_CE) [*2] |=> (!valid_r && O_LASER_DRIVE_ENABLE_LOW))
        else $error("span code 10 did not turn laser off");

    cw_mode_a: assert property (
        (cw_w && valid_w && !ctrl_r.force_off && I_CE)
            |=> (!O_LASER_DRIVE_ENABLE_LOW && O_CONTINUOUS_WAVE))
        else $error("continuous mode did not keep laser on");

    read_clear_a: assert property (
        motion_read |=> ((ctrl_r.cal == `LDC_CAL_OFF) and (I_CE |=> !O_CONTINUOUS_WAVE)))
        else $error("motion read did not end calibration");

    force_off_a: assert property (
        (ctrl_r.force_off && I_CE) |=> O_LASER_DRIVE_ENABLE_LOW)
        else $error("force disable did not hold enable high");

    dac_scale_a: assert property (
        (O_DAC_SCALE == {1'b0, O_DAC_CODE} + `LDC_DAC_OFFSET)
            && (O_DAC_SCALE <= `LDC_DAC_FULL))
        else $error("dac scale does not follow code");

    code_check_a: assert property (
        code_mis_held |=> (!valid_r && O_LASER_DRIVE_ENABLE_LOW))
        else $error("code mismatch did not turn laser off");

    reset_off_a: assert property (
        !$past(I_RSTN) |-> (code_r == `LDC_RST_BYTE && code_inv_r == `LDC_RST_BYTE
            && ctrl_r == drive_ctrl_t'(`LDC_RST_BYTE) && O_LASER_DRIVE_ENABLE_LOW))
        else $error("registers or laser not off after reset");

    span_inv_a: assert property (
        (wr_w && sel_span_inv) |=> (span_inv_r == $past(I_PWDATA[7:6])))
        else $error("range inverse bits not stored");

    drive_gate_a: assert property (
        (I_CE && (!span_ok_w || ctrl_r.force_off || !span_match || !code_match))
            |=> O_LASER_DRIVE_ENABLE_LOW)
        else $error("laser driven while not valid");

endmodule

// ---- tb/tb.sv ----
// self-checking bench for the laser drive register set
`timescale 1ns/1ps

`include "laser_drive_regs.svh"

module tb;
    import laser_drive_pkg::*;

    logic clk;
    logic rstn;
    logic ce;
    logic psel;
    logic penable;
    logic pwrite;
    logic expose;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] o_prdata;
    logic o_pready;
    logic o_pslverr;
    logic o_nen;
    logic [1:0] o_span;
    logic [7:0] o_code;
    logic [8:0] o_scale;
    logic o_cw;
    logic o_valid;
    logic o_irq;
    logic [31:0] rd;
    logic er;
    logic [6:0] zero_idx [5];
    logic [1:0] sp;
    int err_total;
    int num_checks;

    laser_drive_control_regs DUT (
        .I_CLK(clk),
        .I_RSTN(rstn),
        .I_CE(ce),
        .I_PSEL(psel),
        .I_PENABLE(penable),
        .I_PWRITE(pwrite),
        .I_PADDR(paddr),
        .I_PWDATA(pwdata),
        .O_PRDATA(o_prdata),
        .O_PREADY(o_pready),
        .O_PSLVERR(o_pslverr),
        .I_EXPOSE(expose),
        .O_LASER_DRIVE_ENABLE_LOW(o_nen),
        .O_CURRENT_SPAN_SELECT(o_span),
        .O_DAC_CODE(o_code),
        .O_DAC_SCALE(o_scale),
        .O_CONTINUOUS_WAVE(o_cw),
        .O_LASER_POWER_VALID(o_valid),
        .O_IRQ(o_irq)
    );

    // ==========================================
    // bench tasks
    task automatic print_verdict();
        if (err_total == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t %s got %0h exp %0h", $time, msg, got, exp);
        end
    endtask

    // one apb transfer, held until pready is sampled high
    task automatic xfer(input logic w, input logic [6:0] idx, input logic [7:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {3'h0, idx, 2'h0};
        pwdata <= {24'h0, wd};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (o_pready !== 1'b1);
        rd = o_prdata;
        er = o_pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask

    // ==========================================
    // clock, watchdog
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial begin
        #(40 * 4000);
        err_total++;
        print_verdict();
    end

    // ==========================================
    // test sequence
    initial begin
        err_total = 0;
        num_checks = 0;
        rstn = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        expose = 1'b1;
        zero_idx = '{`LDC_IDX_CTRL, `LDC_IDX_CODE, `LDC_IDX_CODE_INV, `LDC_IDX_SPAN_INV,
            `LDC_IDX_IRQ_MASK};
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        #1;
        chk(o_nen, 1'b1, "nen after reset");
        chk(o_valid, 1'b0, "valid after reset");
        chk(o_scale, 9'h081, "scale after reset");
        foreach (zero_idx[i]) begin
            xfer(1'b0, zero_idx[i], 8'h00);
            chk(rd, 32'h0, "reset value");
        end
        // inverse written before its partner
        xfer(1'b1, `LDC_IDX_CODE_INV, 8'hA5);
        xfer(1'b1, `LDC_IDX_CODE, 8'h5A);
        for (int i = 0; i < 4; i++) begin
            sp = i[1:0];
            xfer(1'b1, `LDC_IDX_SPAN_INV, {~sp, 6'h00});
            xfer(1'b1, `LDC_IDX_CTRL, {sp, 6'h00});
            settle();
            chk(o_valid, sp != 2'h2, "span valid");
            chk(o_span, sp, "span select");
            chk(o_nen, sp == 2'h2, "span drive");
            xfer(1'b0, `LDC_IDX_MOTION_A, 8'h00);
            chk(rd, {31'h0, sp != 2'h2}, "motion valid");
        end
        chk(o_code, 8'h5A, "dac code");
        chk(o_scale, 9'h0DB, "dac scale");
        xfer(1'b1, `LDC_IDX_CODE, 8'hFF);
        xfer(1'b1, `LDC_IDX_CODE_INV, 8'h00);
        settle();
        chk(o_scale, 9'h180, "scale full");
        xfer(1'b1, `LDC_IDX_CODE_INV, 8'h01);
        settle();
        chk(o_valid, 1'b0, "inverse off by one");
        chk(o_nen, 1'b1, "inverse off drive");
        xfer(1'b1, `LDC_IDX_CODE_INV, 8'h00);
        xfer(1'b1, `LDC_IDX_CTRL, 8'hC1);
        settle();
        chk(o_nen, 1'b1, "force disable");
        xfer(1'b1, `LDC_IDX_CTRL, 8'hC0);
        settle();
        chk(o_nen, 1'b0, "force released");
        // validity events so far, then calibration mode, its end event and interrupt
        xfer(1'b0, `LDC_IDX_IRQ_STATUS, 8'h00);
        chk(rd, 32'h3, "valid gained and lost");
        xfer(1'b1, `LDC_IDX_IRQ_STATUS, 8'h07);
        xfer(1'b1, `LDC_IDX_IRQ_MASK, 8'h04);
        // clock enable low freezes the drive state
        @(posedge clk);
        ce <= 1'b0;
        expose <= 1'b0;
        settle();
        chk(o_nen, 1'b0, "frozen by clock enable");
        chk(o_pready, 1'b0, "no ready while frozen");
        @(posedge clk);
        ce <= 1'b1;
        settle();
        chk(o_nen, 1'b1, "idle without exposure");
        xfer(1'b1, `LDC_IDX_CTRL, 8'hCA);
        settle();
        chk(o_cw, 1'b1, "cw on");
        chk(o_nen, 1'b0, "cw drive");
        xfer(1'b0, `LDC_IDX_MOTION_B, 8'h00);
        settle();
        chk(o_cw, 1'b0, "cw ended by read");
        chk(o_irq, 1'b1, "irq raised");
        xfer(1'b0, `LDC_IDX_CTRL, 8'h00);
        chk(rd, 32'hC0, "cal cleared");
        xfer(1'b0, `LDC_IDX_IRQ_STATUS, 8'h00);
        chk(rd, 32'h4, "cal end status");
        xfer(1'b1, `LDC_IDX_IRQ_STATUS, 8'h04);
        settle();
        chk(o_irq, 1'b0, "irq cleared");
        xfer(1'b1, `LDC_IDX_IRQ_MASK, 8'h00);
        xfer(1'b1, `LDC_IDX_CTRL, 8'hCA);
        xfer(1'b0, `LDC_IDX_MOTION_A, 8'h00);
        settle();
        chk(o_cw, 1'b0, "cw ended second address");
        xfer(1'b0, `LDC_IDX_IRQ_STATUS, 8'h00);
        chk(rd, 32'h4, "masked status");
        chk(o_irq, 1'b0, "irq masked");
        // unmapped place and reserved bits
        xfer(1'b0, 7'h03, 8'h00);
        chk(er, 1'b1, "unmapped error");
        chk(rd, 32'h0, "unmapped data");
        xfer(1'b1, `LDC_IDX_CTRL, 8'hF1);
        xfer(1'b0, `LDC_IDX_CTRL, 8'h00);
        chk(rd, 32'hC1, "reserved bits");
        chk(er, 1'b0, "mapped no error");
        print_verdict();
    end

endmodule
